// ### design/stc_pkg.sv
// shared constants and types of the sixteen-bit timer/counter core
package stc_pkg;
    // =========================================================
    // register map (byte wide, one index per register)
    localparam int STC_DATA_W = 8;
    localparam int STC_ADDR_W = 4;
    localparam logic [3:0] STC_OFS_COUNT_LOW = 4'h0;
    localparam logic [3:0] STC_OFS_COUNT_HIGH = 4'h1;
    localparam logic [3:0] STC_OFS_TIMER_CTRL = 4'h2;
    localparam logic [3:0] STC_OFS_GATE_CTRL = 4'h3;
    localparam logic [3:0] STC_OFS_STATUS = 4'h4;

    // =========================================================
    // timer_control_reg fields
    localparam int STC_CS_HI = 7;
    localparam int STC_CS_LO = 6;
    localparam int STC_PS_HI = 5;
    localparam int STC_PS_LO = 4;
    localparam int STC_OSCEN_BIT = 3;
    localparam int STC_SYNCDIS_BIT = 2;
    localparam int STC_ON_BIT = 0;
    // gate_control_reg and status fields
    localparam int STC_GATE_EN_BIT = 7;
    localparam int STC_OVF_BIT = 0;
    localparam int STC_WAKE_BIT = 1;

    // =========================================================
    // clock source codes
    localparam logic [1:0] STC_CS_INSTR = 2'h0;
    localparam logic [1:0] STC_CS_SYSTEM = 2'h1;
    localparam logic [1:0] STC_CS_EXT = 2'h2;
    localparam logic [1:0] STC_CS_CAPSENSE = 2'h3;

    // =========================================================
    // reset values and counts
    localparam logic [15:0] STC_COUNT_RST = 16'h0000;
    localparam logic [15:0] STC_COUNT_MAX = 16'hFFFF;
    localparam logic [7:0] STC_BYTE_ZERO = 8'h00;
    localparam logic [1:0] STC_PHASE_LAST = 2'h3;
    localparam logic [2:0] STC_PRE_ZERO = 3'h0;
    localparam logic [2:0] STC_PRE_ONE = 3'h1;
    localparam int STC_SYNC_STAGES = 3;
    localparam int STC_NUM_INPUTS = 3;
    localparam int STC_IN_EXT = 0;
    localparam int STC_IN_XTAL = 1;
    localparam int STC_IN_CPS = 2;

    typedef enum logic [1:0] {
        STC_ST_DISARMED = 2'b00,
        STC_ST_ARMED = 2'b01
    } stc_arm_e;
endpackage

// ### design/stc_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
module stc_pin_sync
    import stc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic pin_in,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic [STC_SYNC_STAGES-1:0] stage;
        logic level;
        logic rise;
        logic fall;
    } stc_sync_s;

    stc_sync_s cur_ff;
    stc_sync_s nxt_ff;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.stage = {cur_ff.stage[STC_SYNC_STAGES-2:0], pin_in};
        nxt_ff.rise = 1'b0;
        nxt_ff.fall = 1'b0;
        // stage 0 is only read by stage 1; stages 1 and 2 must agree
        if (cur_ff.stage[1] == cur_ff.stage[2] &&
            cur_ff.stage[2] != cur_ff.level) begin
            nxt_ff.level = cur_ff.stage[2];
            nxt_ff.rise = cur_ff.stage[2];
            nxt_ff.fall = ~cur_ff.stage[2];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign level = cur_ff.level;
    assign rise = cur_ff.rise;
    assign fall = cur_ff.fall;
endmodule

// ### design/stc_timer_core.sv
// sixteen-bit incrementing timer/counter core with byte register port
`timescale 1ns/1ns
//
// Contract
// - 16-bit up-counter seen as high and low byte; writes change bits.
// - instruction-clock source advances once per instruction cycle.
// - timer_on clear: off; gate_enable clear: always; else gated.
// - clock_select picks system, instruction, capsense, pin or crystal.
// - system clock gives four counts per instruction cycle.
// - external source counts on each rising edge of its input.
// - sync_disable set counts unsynchronised; clear aligns to clock.
// - counter mode needs a falling edge before first counted rise.
// - prescale_select divides the selected clock by 1, 2, 4 or 8.
// - prescaler hidden from software, cleared by any count byte write.
// - crystal_osc_enable starts crystal oscillator, running in sleep.
// - async external counting runs in sleep; overflow wakes processor.
// - byte reads valid while async; software handles overflow between.
// - all ones wraps to zero and sets the overflow flag.
module stc_timer_core
    import stc_pkg::*;
#(
    parameter int COUNT_W = 16,
    parameter int PRE_W = 3
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [STC_ADDR_W-1:0] reg_addr,
    input wire logic [STC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [STC_DATA_W-1:0] reg_rdata,
    input wire logic external_count_input,
    input wire logic crystal_in_pin,
    output logic crystal_out_pin,
    input wire logic capsense_osc_in,
    input wire logic count_enable,
    input wire logic sleep_active,
    output logic overflow_flag,
    output logic wake_request,
    output logic crystal_running
);
    // =========================================================
    // state
    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic [PRE_W-1:0] pre;
        logic [1:0] phase;
        logic pending;
        stc_arm_e arm;
        logic [1:0] clock_select;
        logic [1:0] prescale_select;
        logic crystal_osc_enable;
        logic sync_disable;
        logic timer_on;
        logic gate_enable;
        logic overflow_flag;
        logic wake;
        logic xtal_out;
        logic [STC_DATA_W-1:0] rdata;
    } stc_core_s;

    stc_core_s cur_ff;
    stc_core_s nxt_ff;

    // =========================================================
    // input synchronisers
    logic [STC_NUM_INPUTS-1:0] pin_raw;
    logic [STC_NUM_INPUTS-1:0] pin_level;
    logic [STC_NUM_INPUTS-1:0] pin_rise;
    logic [STC_NUM_INPUTS-1:0] pin_fall;

    // the crystal pin feeds both the count path and the amplifier
    assign pin_raw[STC_IN_EXT] = external_count_input;
    assign pin_raw[STC_IN_XTAL] = crystal_in_pin;
    assign pin_raw[STC_IN_CPS] = capsense_osc_in;

    genvar gi;
    generate
        for (gi = 0; gi < STC_NUM_INPUTS; gi++) begin : g_sync
            stc_pin_sync u_sync (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .pin_in(pin_raw[gi]),
                .level(pin_level[gi]),
                .rise(pin_rise[gi]),
                .fall(pin_fall[gi])
            );
        end
    endgenerate

    // =========================================================
    // decode helpers
    function automatic logic is_external(input logic [1:0] cs);
        return cs == STC_CS_EXT || cs == STC_CS_CAPSENSE;
    endfunction

    // ones mask: the prescaler wraps when its low bits are all set
    function automatic logic [PRE_W-1:0] pre_mask(input logic [1:0] ps);
        return PRE_W'((STC_PRE_ONE << ps) - STC_PRE_ONE);
    endfunction

    // both count bytes share the prescaler clear and the disarm
    function automatic logic is_count_byte(input logic [STC_ADDR_W-1:0] a);
        return a == STC_OFS_COUNT_LOW || a == STC_OFS_COUNT_HIGH;
    endfunction

    // control image for the read mux; bit 1 reads as zero
    function automatic logic [STC_DATA_W-1:0] ctrl_image(
        input logic [1:0] cs,
        input logic [1:0] ps,
        input logic osc,
        input logic sync_off,
        input logic on
    );
        logic [STC_DATA_W-1:0] img;
        img = STC_BYTE_ZERO;
        img[STC_CS_HI:STC_CS_LO] = cs;
        img[STC_PS_HI:STC_PS_LO] = ps;
        img[STC_OSCEN_BIT] = osc;
        img[STC_SYNCDIS_BIT] = sync_off;
        img[STC_ON_BIT] = on;
        return img;
    endfunction

    // status image: overflow and wake sticky bits
    function automatic logic [STC_DATA_W-1:0] status_image(
        input logic ovf,
        input logic wk
    );
        logic [STC_DATA_W-1:0] img;
        img = STC_BYTE_ZERO;
        img[STC_OVF_BIT] = ovf;
        img[STC_WAKE_BIT] = wk;
        return img;
    endfunction

    // =========================================================
    // next state
    logic src_tick;
    logic src_rise;
    logic src_fall;
    logic src_level;
    logic instr_tick;
    logic run_en;
    logic may_run;
    logic pre_tick;
    logic wr_byte;
    logic ext_mode;
    logic wrap_now;

    always_comb begin
        nxt_ff = cur_ff;
        src_tick = 1'b0;
        src_rise = 1'b0;
        src_fall = 1'b0;
        src_level = 1'b0;
        pre_tick = 1'b0;
        wrap_now = 1'b0;
        ext_mode = is_external(cur_ff.clock_select);
        instr_tick = cur_ff.phase == STC_PHASE_LAST;
        wr_byte = reg_wr && is_count_byte(reg_addr);
        // phase runs free from reset, so ticks need no enable of their own
        nxt_ff.phase = cur_ff.phase + 2'h1;

        // source selection
        unique case (cur_ff.clock_select)
            STC_CS_INSTR: src_tick = instr_tick;
            STC_CS_SYSTEM: src_tick = 1'b1;
            STC_CS_EXT: begin
                if (cur_ff.crystal_osc_enable) begin
                    src_rise = pin_rise[STC_IN_XTAL];
                    src_fall = pin_fall[STC_IN_XTAL];
                    src_level = pin_level[STC_IN_XTAL];
                end else begin
                    src_rise = pin_rise[STC_IN_EXT];
                    src_fall = pin_fall[STC_IN_EXT];
                    src_level = pin_level[STC_IN_EXT];
                end
            end
            STC_CS_CAPSENSE: begin
                src_rise = pin_rise[STC_IN_CPS];
                src_fall = pin_fall[STC_IN_CPS];
                src_level = pin_level[STC_IN_CPS];
            end
        endcase

        // enable table, gate logic lives outside
        run_en = cur_ff.timer_on &&
                 (!cur_ff.gate_enable || count_enable);
        // only the unsynchronised external path survives sleep
        may_run = !sleep_active || (ext_mode && cur_ff.sync_disable);

        // counter mode arming: a fall must come first
        if (ext_mode) begin
            // disabling disarms, so the next enable waits for a fall
            if (!cur_ff.timer_on) begin
                nxt_ff.arm = STC_ST_DISARMED;
            end else if (src_fall) begin
                nxt_ff.arm = STC_ST_ARMED;
            end
            if (cur_ff.arm == STC_ST_ARMED && src_rise) begin
                if (cur_ff.sync_disable) begin
                    src_tick = 1'b1;
                end else begin
                    nxt_ff.pending = 1'b1;
                end
            end
            // synchronised edges wait for the instruction phase
            // one edge waits at most; faster input edges merge into it
            if (!cur_ff.sync_disable && cur_ff.pending && instr_tick) begin
                src_tick = 1'b1;
                nxt_ff.pending = src_rise && cur_ff.arm == STC_ST_ARMED;
            end
            // a waiting edge is dropped on entry to async mode
            if (cur_ff.sync_disable) begin
                nxt_ff.pending = 1'b0;
            end
        end else begin
            nxt_ff.pending = 1'b0;
        end

        // prescaler
        if (run_en && may_run && src_tick) begin
            if ((cur_ff.pre & pre_mask(cur_ff.prescale_select)) ==
                pre_mask(cur_ff.prescale_select)) begin
                nxt_ff.pre = STC_PRE_ZERO;
                pre_tick = 1'b1;
            end else begin
                nxt_ff.pre = cur_ff.pre + STC_PRE_ONE;
            end
        end

        // counter and wrap
        wrap_now = pre_tick && cur_ff.count == STC_COUNT_MAX;
        if (pre_tick) begin
            nxt_ff.count = cur_ff.count + COUNT_W'(1);
            if (wrap_now) begin
                nxt_ff.overflow_flag = 1'b1;
                if (sleep_active) begin
                    nxt_ff.wake = 1'b1;
                end
            end
        end

        // register writes; flag set beats a software clear
        // a byte write in a counting cycle wins over the increment in the written byte; the other byte still takes the increment
        if (reg_wr) begin
            unique case (reg_addr)
                STC_OFS_COUNT_LOW: begin
                    nxt_ff.count[STC_DATA_W-1:0] = reg_wdata;
                end
                STC_OFS_COUNT_HIGH: begin
                    nxt_ff.count[COUNT_W-1:STC_DATA_W] = reg_wdata;
                end
                STC_OFS_TIMER_CTRL: begin
                    nxt_ff.clock_select = reg_wdata[STC_CS_HI:STC_CS_LO];
                    nxt_ff.prescale_select = reg_wdata[STC_PS_HI:STC_PS_LO];
                    nxt_ff.crystal_osc_enable = reg_wdata[STC_OSCEN_BIT];
                    nxt_ff.sync_disable = reg_wdata[STC_SYNCDIS_BIT];
                    nxt_ff.timer_on = reg_wdata[STC_ON_BIT];
                    // re-enabling with input low still needs a fall
                    if (reg_wdata[STC_ON_BIT] && !cur_ff.timer_on &&
                        !src_level) begin
                        nxt_ff.arm = STC_ST_DISARMED;
                    end
                end
                STC_OFS_GATE_CTRL: begin
                    nxt_ff.gate_enable = reg_wdata[STC_GATE_EN_BIT];
                end
                STC_OFS_STATUS: begin
                    if (!reg_wdata[STC_OVF_BIT] && !wrap_now) begin
                        nxt_ff.overflow_flag = 1'b0;
                    end
                    if (!reg_wdata[STC_WAKE_BIT] &&
                        !(wrap_now && sleep_active)) begin
                        nxt_ff.wake = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // byte write clears prescaler and disarms counter mode
        if (wr_byte) begin
            nxt_ff.pre = STC_PRE_ZERO;
            nxt_ff.arm = STC_ST_DISARMED;
            nxt_ff.pending = 1'b0;
        end

        // crystal amplifier, independent of sleep
        // inverts the synchronised pin; the raw pin never reaches xtal_out directly
        nxt_ff.xtal_out = cur_ff.crystal_osc_enable &&
                          !pin_level[STC_IN_XTAL];

        // read data from the registered count, never torn
        // zero outside the read slot, so the port idles at a known level
        nxt_ff.rdata = STC_BYTE_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                STC_OFS_COUNT_LOW: begin
                    nxt_ff.rdata = cur_ff.count[STC_DATA_W-1:0];
                end
                STC_OFS_COUNT_HIGH: begin
                    nxt_ff.rdata = cur_ff.count[COUNT_W-1:STC_DATA_W];
                end
                STC_OFS_TIMER_CTRL: begin
                    nxt_ff.rdata = ctrl_image(cur_ff.clock_select,
                        cur_ff.prescale_select, cur_ff.crystal_osc_enable,
                        cur_ff.sync_disable, cur_ff.timer_on);
                end
                STC_OFS_GATE_CTRL: begin
                    nxt_ff.rdata[STC_GATE_EN_BIT] = cur_ff.gate_enable;
                end
                STC_OFS_STATUS: begin
                    nxt_ff.rdata = status_image(cur_ff.overflow_flag,
                        cur_ff.wake);
                end
                default: nxt_ff.rdata = STC_BYTE_ZERO;
            endcase
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_ff <= '0;
            cur_ff.count <= STC_COUNT_RST;
            cur_ff.arm <= STC_ST_DISARMED;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // every output is a plain copy of a state flop
    assign reg_rdata = cur_ff.rdata;
    assign overflow_flag = cur_ff.overflow_flag;
    assign wake_request = cur_ff.wake;
    assign crystal_out_pin = cur_ff.xtal_out;
    assign crystal_running = cur_ff.crystal_osc_enable;
endmodule

// ### tb/stc_timer_core_monitor.sv
// port-level assertions of the timer core
`timescale 1ns/1ns
module stc_chk
    import stc_pkg::*;
#(
    parameter int COUNT_W = 16,
    parameter int PRE_W = 3
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [STC_ADDR_W-1:0] reg_addr,
    input wire logic [STC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [STC_DATA_W-1:0] reg_rdata,
    input wire logic crystal_out_pin,
    input wire logic sleep_active,
    input wire logic overflow_flag,
    input wire logic wake_request,
    input wire logic crystal_running
);
    // ==========================================
    // register port, status and oscillator
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    rd_quiet_a: assert property (
        reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data outside read slot");
    unmapped_rd_a: assert property (
        reg_rd && reg_addr > STC_OFS_STATUS |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    ctrl_back_a: assert property (
        reg_wr && reg_addr == STC_OFS_TIMER_CTRL ##2
        reg_rd && reg_addr == STC_OFS_TIMER_CTRL |=>
        (reg_rdata & 8'hFD) == ($past(reg_wdata, 3) & 8'hFD))
        else $error("control read back differs");
    osc_en_a: assert property (
        reg_wr && reg_addr == STC_OFS_TIMER_CTRL |=>
        crystal_running == $past(reg_wdata[STC_OSCEN_BIT]))
        else $error("oscillator enable not followed");
    amp_off_a: assert property (
        !crystal_running |=> !crystal_out_pin)
        else $error("amplifier drives while disabled");
    ovf_hold_a: assert property (
        overflow_flag && !(reg_wr && reg_addr == STC_OFS_STATUS)
        |=> overflow_flag)
        else $error("overflow flag dropped");
    status_rd_a: assert property (
        reg_rd && reg_addr == STC_OFS_STATUS |=>
        reg_rdata[1:0] == {$past(wake_request), $past(overflow_flag)})
        else $error("status read mismatch");
    wake_cause_a: assert property (
        $rose(wake_request) |-> $past(sleep_active) && overflow_flag)
        else $error("wake without overflow in sleep");
endmodule

bind stc_timer_core stc_chk #(.COUNT_W(COUNT_W), .PRE_W(PRE_W)) chk_i (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .crystal_out_pin(crystal_out_pin),
    .sleep_active(sleep_active),
    .overflow_flag(overflow_flag),
    .wake_request(wake_request),
    .crystal_running(crystal_running)
);

// ### tb/stc_src_model.sv
// far-side sources: count pin, capacitive oscillator, crystal
`timescale 1ns/1ns
module stc_src_model (
    input wire logic sys_clk,
    input wire logic crystal_out_pin,
    output logic ext_pin,
    output logic cps_pin,
    output logic xtal_pin
);
    logic [2:0] div_ff = 3'h0;
    initial begin
        ext_pin = 1'b0;
        cps_pin = 1'b0;
        xtal_pin = 1'b0;
    end
    // ==========================================
    // crystal swings only through the amplifier
    always @(posedge sys_clk) begin
        div_ff <= div_ff + 3'h1;
        if (div_ff == 3'h7) begin
            xtal_pin <= crystal_out_pin;
        end
    end
    // pulses start from low, so the first rise of a burst is not counted and its fall arms
    task automatic pulses(input int sel, input int n);
        for (int i = 0; i < n; i++) begin
            if (sel == 0) ext_pin <= 1'b1;
            else cps_pin <= 1'b1;
            repeat (8) @(posedge sys_clk);
            ext_pin <= 1'b0;
            cps_pin <= 1'b0;
            repeat (8) @(posedge sys_clk);
        end
    endtask
endmodule

// ### tb/stc_timer_core_bench.sv
// register-level bench of the timer core
`timescale 1ns/1ns
module stc_timer_core_bench
    import stc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic count_enable = 1'b0;
    logic sleep_active = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] d;
    logic ext_pin, cps_pin, xtal_pin, xtal_out, ovf, wake, xrun;
    logic [7:0] ext_mode [3] = '{8'h81, 8'h85, 8'hC5};
    int fails = 0;
    int num_checks = 0;

    always #5 sys_clk = ~sys_clk;

    stc_timer_core DUT (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .external_count_input(ext_pin),
        .crystal_in_pin(xtal_pin), .crystal_out_pin(xtal_out),
        .capsense_osc_in(cps_pin), .count_enable(count_enable),
        .sleep_active(sleep_active), .overflow_flag(ovf),
        .wake_request(wake), .crystal_running(xrun)
    );
    stc_src_model P (
        .sys_clk(sys_clk), .crystal_out_pin(xtal_out),
        .ext_pin(ext_pin), .cps_pin(cps_pin), .xtal_pin(xtal_pin)
    );

    // ==========================================
    // bus cycles and comparisons
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
        @(posedge sys_clk);
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic clr();
        wr(STC_OFS_TIMER_CTRL, 8'h00);
        wr(STC_OFS_COUNT_LOW, 8'h00);
        wr(STC_OFS_COUNT_HIGH, 8'h00);
    endtask
    // exactly 64 enabled edges: enable strobe edge to stop strobe edge
    task automatic run(input logic [7:0] c);
        clr();
        wr(STC_OFS_TIMER_CTRL, c);
        repeat (62) @(posedge sys_clk);
        wr(STC_OFS_TIMER_CTRL, c & 8'hFE);
        rd(STC_OFS_COUNT_LOW);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================
    // scenarios
    initial begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        results();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 5; i++) begin
            rd(4'(i));
            chk("reset value", 8'h00, d);
        end
        rd(4'hF);
        chk("unmapped", 8'h00, d);
        wr(STC_OFS_COUNT_LOW, 8'hA5);
        wr(STC_OFS_COUNT_HIGH, 8'h5A);
        rd(STC_OFS_COUNT_LOW);
        chk("low byte", 8'hA5, d);
        rd(STC_OFS_COUNT_HIGH);
        chk("high byte", 8'h5A, d);
        wr(STC_OFS_TIMER_CTRL, 8'hFC);
        rd(STC_OFS_TIMER_CTRL);
        chk("control", 8'hFC, d & 8'hFD);
        run(8'h40);
        chk("off", 8'h00, d);
        run(8'h01);
        chk("instr clock", 8'h10, d);
        for (int p = 0; p < 4; p++) begin
            run(8'h41 | 8'(p << 4));
            chk("sys prescale", 8'(64 >> p), d);
        end
        wr(STC_OFS_GATE_CTRL, 8'h80);
        run(8'h41);
        chk("gate closed", 8'h00, d);
        count_enable <= 1'b1;
        run(8'h41);
        chk("gate open", 8'h40, d);
        wr(STC_OFS_GATE_CTRL, 8'h00);
        sleep_active <= 1'b1;
        run(8'h41);
        chk("sleep sync", 8'h00, d);
        sleep_active <= 1'b0;
        for (int m = 0; m < 3; m++) begin
            clr();
            wr(STC_OFS_TIMER_CTRL, ext_mode[m]);
            P.pulses(m / 2, 5);
            repeat (8) @(posedge sys_clk);
            wr(STC_OFS_TIMER_CTRL, 8'h00);
            rd(STC_OFS_COUNT_LOW);
            chk("edge count", 8'h04, d);
        end
        clr();
        wr(STC_OFS_COUNT_LOW, 8'hFE);
        wr(STC_OFS_COUNT_HIGH, 8'hFF);
        sleep_active <= 1'b1;
        wr(STC_OFS_TIMER_CTRL, 8'h85);
        P.pulses(0, 4);
        for (int i = 0; i < 100 && wake !== 1'b1; i++) @(posedge sys_clk);
        chk("wake", 8'h01, {7'h00, wake});
        chk("overflow pin", 8'h01, {7'h00, ovf});
        sleep_active <= 1'b0;
        wr(STC_OFS_TIMER_CTRL, 8'h00);
        rd(STC_OFS_COUNT_LOW);
        chk("wrap low", 8'h01, d);
        rd(STC_OFS_COUNT_HIGH);
        chk("wrap high", 8'h00, d);
        rd(STC_OFS_STATUS);
        chk("status", 8'h03, d);
        wr(STC_OFS_STATUS, 8'h00);
        rd(STC_OFS_STATUS);
        chk("status clear", 8'h00, d);
        // oscillator first, counting only after it has settled
        wr(STC_OFS_TIMER_CTRL, 8'h08);
        repeat (64) @(posedge sys_clk);
        chk("osc running", 8'h01, {7'h00, xrun});
        wr(STC_OFS_COUNT_LOW, 8'h00);
        wr(STC_OFS_TIMER_CTRL, 8'h8D);
        repeat (160) @(posedge sys_clk);
        wr(STC_OFS_TIMER_CTRL, 8'h08);
        rd(STC_OFS_COUNT_LOW);
        chk("crystal count", 8'h01, {7'h00, d != 8'h00});
        results();
    end
endmodule
